// *** design/low_voltage_detect_ctrl.sv ***
/*
 * Low-voltage detector control: APB registers, comparator
 * synchronisation, internal reset and interrupt generation.
 * Assumes the analog comparator gives below-threshold levels
 * asynchronously, and chip_reset_active is high on pclk while
 * the chip is in any reset, including the one this block makes.
 */
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lvd_consts.svh"
module low_voltage_detect_ctrl
    import lvd_pkg::*;
#(
    parameter int STAB_CYC = `LVD_STAB_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator
    input wire logic supply_below_async,
    input wire logic external_sense_pin_below_async,
    output logic comparator_on,
    output logic sense_source_select,
    output logic [`LVD_THR_W-1:0] threshold_code_field,
    // Chip reset and interrupt fabric
    input wire logic chip_reset_active,
    output logic undervolt_reset,
    output logic detector_irq_request,
    output logic detector_irq_out
);
    // ****************************************
    // Declarations
    // ****************************************
    state_t st_ff; // Registered state
    state_t nxt_st; // Next state
    logic supply_below; // Synchronised supply compare
    logic pin_below; // Synchronised pin compare
    logic sel_below; // Compare of the chosen source
    logic lvl_now; // Level flag as it will be
    logic irq_req; // Crossing seen this cycle
    logic settled; // Stabilisation time elapsed
    logic wr; // APB write access
    logic rd_setup; // APB read setup
    logic mapped; // Address hits a register
    logic ord_rst; // Reset not made by this block

    // ****************************************
    // Comparator synchronisers
    // ****************************************
    // Async compare results must not reach logic directly
    bit_sync u_sync_supply (
        .pclk(pclk),
        .presetn(presetn),
        .d(supply_below_async),
        .q(supply_below)
    );

    bit_sync u_sync_pin (
        .pclk(pclk),
        .presetn(presetn),
        .d(external_sense_pin_below_async),
        .q(pin_below)
    );

    // Stabilisation timer, runs only while settling
    settle_timer #(
        .CYC(STAB_CYC)
    ) u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .run(st_ff.fsm == st_settle),
        .done(settled)
    );

    // ****************************************
    // Detection logic
    // ****************************************
    // Pick the comparator that the source bit names
    assign sel_below = st_ff.src ? pin_below : supply_below;
    // Flag reads zero while disabled
    assign lvl_now = st_ff.en && sel_below;
    // Any change of the flag while enabled in interrupt mode is a request; the
    // old flag is zero while off, so enabling while low requests
    assign irq_req = st_ff.en && !st_ff.mode && (lvl_now != st_ff.lvl);

    // ****************************************
    // APB decode
    // ****************************************
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        unique case (paddr)
            `LVD_OFS_CTRL, `LVD_OFS_THR, `LVD_OFS_CAUSE,
            `LVD_OFS_IRQ, `LVD_OFS_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // No wait states; unmapped access flagged in access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // Chip reset that this block did not cause
    assign ord_rst = chip_reset_active && !st_ff.rst;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lvl = lvl_now;
        // Reset held while enabled, in reset mode and low; setting
        // the mode while high leaves it released
        nxt_st.rst = st_ff.en && st_ff.mode && sel_below;
        // Stabilisation tracker
        if (!st_ff.en) begin
            nxt_st.fsm = st_off;
        end else begin
            unique case (st_ff.fsm)
                st_off: nxt_st.fsm = st_settle;
                st_settle: nxt_st.fsm = settled ? st_run : st_settle;
                st_run: nxt_st.fsm = st_run;
            endcase
        end
        // Register writes
        if (wr) begin
            unique case (paddr)
                `LVD_OFS_CTRL: begin
                    nxt_st.mode = pwdata[`LVD_BIT_MODE];
                    nxt_st.src = pwdata[`LVD_BIT_SRC];
                    nxt_st.en = pwdata[`LVD_BIT_EN];
                end
                `LVD_OFS_THR: begin
                    nxt_st.thr = pwdata[`LVD_THR_W-1:0];
                end
                `LVD_OFS_CAUSE: begin
                    // Write one clears
                    if (pwdata[`LVD_BIT_CAUSE]) begin
                        nxt_st.cause = 1'b0;
                    end
                end
                `LVD_OFS_IRQ: begin
                    // Writing zero clears the pending flag
                    if (!pwdata[`LVD_BIT_PEND]) begin
                        nxt_st.pend = 1'b0;
                    end
                    nxt_st.mask = pwdata[`LVD_BIT_MASK];
                end
                default: begin
                end
            endcase
        end
        // Chip reset: mask set and threshold cleared for every
        // source; control bits kept through our own reset
        if (chip_reset_active) begin
            nxt_st.mask = `LVD_RST_MASK;
            nxt_st.thr = `LVD_RST_THR;
            nxt_st.pend = 1'b0;
        end
        if (ord_rst) begin
            nxt_st.en = 1'b0;
            nxt_st.mode = 1'b0;
            nxt_st.src = 1'b0;
        end
        // Hardware set beats any clear in the same cycle
        if (irq_req) begin
            nxt_st.pend = 1'b1;
        end
        if (nxt_st.rst && !st_ff.rst) begin
            nxt_st.cause = 1'b1;
        end
        // Read data captured in setup, stable through access
        if (rd_setup) begin
            nxt_st.prdata = 32'h0000_0000;
            unique case (paddr)
                `LVD_OFS_CTRL: begin
                    nxt_st.prdata[`LVD_BIT_LEVEL] = st_ff.lvl;
                    nxt_st.prdata[`LVD_BIT_MODE] = st_ff.mode;
                    nxt_st.prdata[`LVD_BIT_SRC] = st_ff.src;
                    nxt_st.prdata[`LVD_BIT_EN] = st_ff.en;
                end
                `LVD_OFS_THR: nxt_st.prdata[`LVD_THR_W-1:0] = st_ff.thr;
                `LVD_OFS_CAUSE: nxt_st.prdata[`LVD_BIT_CAUSE] = st_ff.cause;
                `LVD_OFS_IRQ: begin
                    nxt_st.prdata[`LVD_BIT_PEND] = st_ff.pend;
                    nxt_st.prdata[`LVD_BIT_MASK] = st_ff.mask;
                end
                `LVD_OFS_STAT: nxt_st.prdata[`LVD_BIT_READY] = (st_ff.fsm == st_run);
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{fsm: st_off, thr: `LVD_RST_THR, mask: `LVD_RST_MASK, prdata: 32'h0000_0000,
                       default: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = st_ff.prdata;
    assign comparator_on = st_ff.en;
    assign sense_source_select = st_ff.src;
    assign threshold_code_field = st_ff.thr;
    assign undervolt_reset = st_ff.rst;
    // Request pulse is combinational; a handshake-class output
    assign detector_irq_request = irq_req;
    assign detector_irq_out = st_ff.pend && !st_ff.mask;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_supply_reset_hold: assert property (
        st_ff.en && st_ff.mode && !st_ff.src && supply_below |=> undervolt_reset)
        else $error("supply low in reset mode without reset");
    a_pin_reset_release: assert property (
        st_ff.en && st_ff.mode && st_ff.src && !pin_below |=> !undervolt_reset)
        else $error("pin high in reset mode but reset held");
    a_supply_irq_cross: assert property (
        st_ff.en && !st_ff.mode && !st_ff.src && (supply_below != st_ff.lvl)
        |-> detector_irq_request ##1 (st_ff.lvl == $past(supply_below)))
        else $error("supply crossing gave no request");
    a_pin_irq_cross: assert property (
        st_ff.en && !st_ff.mode && st_ff.src && pin_below && !st_ff.lvl
        |-> detector_irq_request ##1 st_ff.pend)
        else $error("pin crossing gave no pending request");
    a_level_readback: assert property (
        rd_setup && paddr == `LVD_OFS_CTRL |=> prdata[`LVD_BIT_LEVEL] == $past(st_ff.lvl))
        else $error("level flag read back wrong");
    // Only a start from off restarts settling; rewriting other bits while running must not
    a_enable_write: assert property (
        wr && paddr == `LVD_OFS_CTRL && pwdata[`LVD_BIT_EN] && !comparator_on && !chip_reset_active
        |=> comparator_on ##1 st_ff.fsm == st_settle)
        else $error("enable write did not start detector");
    a_no_reset_above: assert property (
        st_ff.en && st_ff.mode && !sel_below |=> !undervolt_reset)
        else $error("reset raised while above threshold");
    a_mask_on_reset: assert property (
        chip_reset_active |=> st_ff.mask && !detector_irq_out)
        else $error("chip reset left interrupt unmasked");
    a_cause_record: assert property (
        $rose(undervolt_reset) |-> st_ff.cause)
        else $error("detector reset not recorded");
    a_irq_gating: assert property (
        detector_irq_request |-> comparator_on && !st_ff.mode)
        else $error("request outside interrupt mode");
    a_own_reset_keep: assert property (
        chip_reset_active && st_ff.rst && !wr |=> $stable(st_ff.en) && $stable(st_ff.src))
        else $error("own reset cleared control bits");
    a_thr_clear: assert property (
        chip_reset_active |=> threshold_code_field == `LVD_RST_THR)
        else $error("threshold not cleared by reset");
    a_irq_pend_set: assert property (
        detector_irq_request |=> st_ff.pend)
        else $error("request did not set pending");
    a_level_disabled: assert property (
        !comparator_on |=> !st_ff.lvl)
        else $error("level flag set while disabled");
    a_foreign_clear: assert property (
        ord_rst |=> !comparator_on && !st_ff.mode && !sense_source_select)
        else $error("foreign reset kept control bits");
    a_reset_needs_mode: assert property (
        !(st_ff.en && st_ff.mode) |=> !undervolt_reset)
        else $error("reset raised outside reset mode");
    a_settle_to_run: assert property (
        st_ff.en && settled |=> st_ff.fsm == st_run)
        else $error("settling did not end in run");

    c_reset_mode: cover property (st_ff.mode && $rose(undervolt_reset));
    c_irq_rise: cover property (detector_irq_request && lvl_now);
    c_irq_fall: cover property (detector_irq_request && !lvl_now);
    c_settled: cover property ($rose(st_ff.fsm == st_run));
    c_foreign_reset: cover property (ord_rst);
endmodule : low_voltage_detect_ctrl

// *** design/lvd_consts.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the
 * low-voltage detector control block.
 * Assumes a 25 MHz APB clock and 32-bit aligned register words.
 */
// Function
// - Supply source, reset mode: reset while below
// - Pin source, reset mode: reset while below
// - Supply source, interrupt mode: request on both crossings
// - Pin source, interrupt mode: request on both crossings
// - Level flag at control bit 0 shows below
// - Mode at bit 1, source at bit 2
// - Enable bit 7 starts the detector
// - Interrupt mode may request right at enable
// - No reset when mode set while above
// - Any reset sets the interrupt mask
// - Detector reset recorded in cause bit 0
// - Request only while enabled and mode zero
// - Control bits survive only the detector's reset
// - Any reset clears threshold select to zero
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define LVD_OFS_CTRL 12'h000
`define LVD_OFS_THR 12'h004
`define LVD_OFS_CAUSE 12'h008
`define LVD_OFS_IRQ 12'h00c
`define LVD_OFS_STAT 12'h010

// ****************************************
// Field positions
// ****************************************
`define LVD_BIT_LEVEL 0
`define LVD_BIT_MODE 1
`define LVD_BIT_SRC 2
`define LVD_BIT_EN 7
`define LVD_BIT_PEND 0
`define LVD_BIT_MASK 1
`define LVD_BIT_CAUSE 0
`define LVD_BIT_READY 0
`define LVD_THR_W 4

// ****************************************
// Reset values
// ****************************************
`define LVD_RST_THR 4'h0
`define LVD_RST_MASK 1'b1

// ****************************************
// Timing
// ****************************************
`define LVD_CLK_KHZ 25000
`define LVD_STAB_NS 10000
// Longest wait, rounded up to whole cycles
`define LVD_STAB_CYC ((`LVD_STAB_NS * `LVD_CLK_KHZ + 999999) / 1000000)

`endif

// *** design/lvd_pkg.sv ***
/*
 * Types of the low-voltage detector control block.
 * Assumes lvd_consts.svh for the widths it uses.
 */
`include "lvd_consts.svh"
package lvd_pkg;
    // ****************************************
    // Stabilisation tracker states
    // ****************************************
    typedef enum logic [2:0] {
        st_off = 3'b001,
        st_settle = 3'b010,
        st_run = 3'b100
    } fsm_t;

    // ****************************************
    // Whole state of the control block
    // ****************************************
    typedef struct packed {
        fsm_t fsm;
        logic en;
        logic mode;
        logic src;
        logic [`LVD_THR_W-1:0] thr;
        logic lvl;
        logic mask;
        logic pend;
        logic cause;
        logic rst;
        logic [31:0] prdata;
    } state_t;
endpackage : lvd_pkg

// *** design/bit_sync.sv ***
/*
 * Two-flop synchroniser for one level.
 * Assumes the input is asynchronous to pclk.
 */
`timescale 1ns/1ps
module bit_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level
    input wire logic d,
    output logic q
);
    // First stage, read only by the second
    logic meta_ff;

    // Two stages, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : bit_sync

// *** design/settle_timer.sv ***
/*
 * Counts the comparator stabilisation time while run is high.
 * Assumes run drops whenever the detector is disabled.
 */
`timescale 1ns/1ps
module settle_timer #(
    parameter int CYC = 250
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    output logic done
);
    localparam int W = $clog2(CYC + 1);
    localparam logic [W-1:0] LAST = W'(CYC - 1);
    // Elapsed cycles
    logic [W-1:0] cnt_ff;

    // Count up, restart whenever run falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (!run) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LAST) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    assign done = run && (cnt_ff == LAST);
endmodule : settle_timer

// *** tb/lvd_far_side.sv ***
/*
 * Far-side model: analog comparator and chip reset fabric.
 * Assumes the bench sets supply_low and pin_low as the analog truth.
 */
`timescale 1ns/1ps
module lvd_far_side (
    // Analog truth from the bench
    input wire logic supply_low,
    input wire logic pin_low,
    input wire logic other_reset,
    // Block side
    input wire logic comparator_on,
    input wire logic undervolt_reset,
    output logic supply_below_async,
    output logic external_sense_pin_below_async,
    output logic chip_reset_active
);
    // Comparator idles low when off; skewed so it never lands on an edge
    assign #3 supply_below_async = comparator_on & supply_low;
    assign #3 external_sense_pin_below_async = comparator_on & pin_low;
    // Our own reset is part of the chip reset
    assign chip_reset_active = undervolt_reset | other_reset;
endmodule : lvd_far_side

// *** tb/low_voltage_detect_ctrl_tb_top.sv ***
/*
 * Self-checking bench of the detector control block.
 * Assumes the far-side model and a 25 MHz pclk.
 */
`timescale 1ns/1ps
`include "lvd_consts.svh"
module low_voltage_detect_ctrl_tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic supply_low = 0, pin_low = 0, other_reset = 0;
    logic sup_b, pin_b, comp_on, undervolt_reset, chip_rst, irq_req, irq_out, src_sel;
    logic [3:0] thr_code;
    int num_errors = 0, checks = 0, irq_cnt = 0, base;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic se;} row_t;
    // Plain register cases: access, expected read, expected error
    row_t rows[11] = '{
        '{0, `LVD_OFS_CTRL, 0, 0, 0}, '{0, `LVD_OFS_THR, 0, 0, 0},
        '{0, `LVD_OFS_IRQ, 0, 32'h2, 0}, '{0, `LVD_OFS_CAUSE, 0, 0, 0},
        '{0, 12'h014, 0, 0, 1}, '{1, 12'h014, 32'hffffffff, 0, 1},
        '{1, `LVD_OFS_THR, 32'hffffffff, 0, 0}, '{0, `LVD_OFS_THR, 0, 32'hf, 0},
        '{1, `LVD_OFS_CTRL, 32'h84, 0, 0}, '{0, `LVD_OFS_CTRL, 0, 32'h84, 0},
        '{1, `LVD_OFS_CTRL, 0, 0, 0}};

    low_voltage_detect_ctrl #(.STAB_CYC(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_below_async(sup_b),
        .external_sense_pin_below_async(pin_b), .comparator_on(comp_on), .sense_source_select(src_sel),
        .threshold_code_field(thr_code), .chip_reset_active(chip_rst), .undervolt_reset(undervolt_reset),
        .detector_irq_request(irq_req), .detector_irq_out(irq_out));
    lvd_far_side far_side (.supply_low(supply_low), .pin_low(pin_low), .other_reset(other_reset),
        .comparator_on(comp_on), .undervolt_reset(undervolt_reset), .supply_below_async(sup_b),
        .external_sense_pin_below_async(pin_b), .chip_reset_active(chip_rst));

    // 40 ns clock
    initial forever #20 pclk = ~pclk;
    // Pulses are one cycle wide, so count them at every edge
    always @(posedge pclk) if (irq_req === 1'b1) irq_cnt <= irq_cnt + 1;

    // ****************************************
    // Tasks
    // ****************************************
    task results;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, entered just after an edge; leaves one idle cycle
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            chk(0, 1);
            results;
        end
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    // Poll the settle status under a bound
    task wait_stab;
        int n;
        n = 0;
        rd = 0;
        while (rd[0] !== 1'b1 && n < 20) begin
            apb(0, `LVD_OFS_STAT, 0);
            n++;
        end
        if (rd[0] !== 1'b1) begin
            chk(0, 1);
            results;
        end
    endtask : wait_stab
    task low(input int s, input logic v);
        if (s != 0) pin_low <= v;
        else supply_low <= v;
        repeat (6) @(posedge pclk);
    endtask : low

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk(rd, rows[i].e);
            chk(32'(err), 32'(rows[i].se));
        end
        // Reset mode, supply then pin
        for (int s = 0; s < 2; s++) begin
            base = irq_cnt;
            apb(1, `LVD_OFS_IRQ, 32'h2);
            apb(1, `LVD_OFS_THR, 32'h3);
            chk(32'(thr_code), 32'h3);
            apb(1, `LVD_OFS_CTRL, 32'h80 | (s << 2));
            wait_stab;
            apb(0, `LVD_OFS_CTRL, 0);
            chk(rd & 32'h1, 0);
            apb(1, `LVD_OFS_CTRL, 32'h82 | (s << 2));
            repeat (6) @(posedge pclk);
            chk(32'(undervolt_reset), 0);
            low(s, 1);
            chk(32'(undervolt_reset), 1);
            chk(32'(src_sel), 32'(s));
            apb(0, `LVD_OFS_CTRL, 0);
            chk(rd, 32'h83 | (s << 2));
            apb(0, `LVD_OFS_CAUSE, 0);
            chk(rd, 1);
            low(s, 0);
            chk(32'(undervolt_reset), 0);
            chk(32'(thr_code), 0);
            chk(32'(irq_cnt - base), 0);
            apb(1, `LVD_OFS_CTRL, 32'h80 | (s << 2));
            apb(1, `LVD_OFS_CTRL, 0);
            apb(1, `LVD_OFS_CAUSE, 1);
        end
        // Interrupt mode: both crossings raise a request
        for (int s = 0; s < 2; s++) begin
            apb(1, `LVD_OFS_IRQ, 32'h2);
            apb(1, `LVD_OFS_CTRL, 32'h80 | (s << 2));
            wait_stab;
            apb(1, `LVD_OFS_IRQ, 0);
            base = irq_cnt;
            low(s, 1);
            low(s, 0);
            chk(32'(irq_cnt - base), 2);
            chk(32'(irq_out), 1);
            apb(1, `LVD_OFS_CTRL, 0);
            low(s, 1);
            low(s, 0);
            chk(32'(irq_cnt - base), 2);
            apb(1, `LVD_OFS_IRQ, 32'h2);
        end
        // Switch to a supply source already low in interrupt mode, masked
        base = irq_cnt;
        supply_low <= 1;
        apb(1, `LVD_OFS_CTRL, 32'h86);
        apb(1, `LVD_OFS_CTRL, 32'h84);
        apb(1, `LVD_OFS_CTRL, 32'h80);
        repeat (6) @(posedge pclk);
        chk(32'(irq_cnt - base), 1);
        chk(32'(irq_out), 0);
        // A foreign chip reset clears the control bits
        apb(1, `LVD_OFS_IRQ, 0);
        other_reset <= 1;
        repeat (2) @(posedge pclk);
        other_reset <= 0;
        supply_low <= 0;
        apb(0, `LVD_OFS_CTRL, 0);
        chk(rd, 0);
        apb(0, `LVD_OFS_IRQ, 0);
        chk(rd, 32'h2);
        results;
    end
endmodule : low_voltage_detect_ctrl_tb_top
